// [common/power_seq_pkg.sv]
// constants and types for the converter power-mode sequencer
// Overview of operation
// - rise after edge 10: stay on, abort
// - fourteen clocks; output drives until rise
// - four zero bits follow the result
// - further clocks shift other converter's result
// - output three-states at 32nd edge
// - rise in edges 2..9 enters partial
// - rise before edge 2 keeps normal
// - partial: analog off, reference kept on
// - dummy conversion wakes; valid after delay
// - early rise in partial stays partial
// - early rise cancels a started wake-up
// - window rise in partial enters full
// - full: everything off, reference included
// - select fall samples, starts, drives outputs
// - two leading zeros, twelve-bit result
// - coincident clock edge at fall ignored
package power_seq_pkg;
    localparam int          RES_W       = 12;
    localparam int          WORD_W      = 24;
    localparam int          FIFO_DEPTH  = 16;
    localparam int          WAKE_W      = 17;
    localparam logic [5:0]  CNT_LOAD    = 6'h01;
    localparam logic [5:0]  CNT_GLITCH  = 6'h02;
    localparam logic [5:0]  CNT_KEEP    = 6'h0a;
    localparam logic [5:0]  CNT_DATA    = 6'h0e;
    localparam logic [5:0]  CNT_TAIL    = 6'h11;
    localparam logic [5:0]  FRAME_TOP   = 6'h1f;
    localparam logic [5:0]  CNT_LAST    = 6'h20;
    localparam logic [5:0]  CNT_SAT     = 6'h21;
    localparam logic [1:0]  LEAD_ZEROS  = 2'h0;
    localparam logic [3:0]  GAP_ZEROS   = 4'h0;
    localparam logic        SELECT_IDLE = 1'b1;
    localparam logic        SCLK_IDLE   = 1'b0;
    localparam real         CLK_PERIOD_NS   = 20.0;
    localparam real         PARTIAL_WAKE_US = 1.0;
    localparam real         FULL_WAKE_MS    = 1.5;
    localparam int          PARTIAL_WAKE_CYC =
        int'($ceil(PARTIAL_WAKE_US * 1000.0 / CLK_PERIOD_NS));
    localparam int          FULL_WAKE_CYC =
        int'($ceil(FULL_WAKE_MS * 1000000.0 / CLK_PERIOD_NS));
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_PARTIAL,
        MODE_FULL
    } pwr_mode_e;
endpackage

// [common/stream_if.sv]
// valid/ready word carrier between the sequencer and its buffer
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int WIDTH = 24);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [hw/pin_sync.sv]
// three-flop pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(parameter logic INIT = 1'b0)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic rise_reg;
    logic fall_reg;
    logic agree;

    assign agree = (s2_reg == s3_reg);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
        end
        else
        begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            level_reg <= INIT;
            rise_reg  <= 1'b0;
            fall_reg  <= 1'b0;
        end
        else
        begin
            rise_reg <= agree && s3_reg && !level_reg;
            fall_reg <= agree && !s3_reg && level_reg;
            if (agree)
                level_reg <= s3_reg;
        end
    end

    assign level = level_reg;
    assign rise  = rise_reg;
    assign fall  = fall_reg;
endmodule // pin_sync
`default_nettype wire

// [hw/result_fifo.sv]
// result buffer memory with registered read word
`timescale 1ns/1ns
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
)
(
    input  wire logic clk,
    input  wire logic rst,
    stream_if.snk     wr,
    stream_if.src     rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      fill_reg;
    logic             out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic             push;
    logic             load;

    assign wr.ready = (fill_reg != (AW+1)'(DEPTH));
    assign push     = wr.valid && wr.ready;
    assign load     = (fill_reg != '0) && (!out_valid_reg || rd.ready);

    always_ff @(posedge clk)
    begin
        if (push)
            mem_reg[wptr_reg] <= wr.data;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            fill_reg <= '0;
        end
        else
        begin
            if (push)
                wptr_reg <= AW'((wptr_reg + 1'b1) % DEPTH);
            if (load)
                rptr_reg <= AW'((rptr_reg + 1'b1) % DEPTH);
            fill_reg <= fill_reg + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    // output stage holds the head word until taken
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end
        else if (load)
        begin
            out_valid_reg <= 1'b1;
            out_data_reg  <= mem_reg[rptr_reg];
        end
        else if (rd.ready)
            out_valid_reg <= 1'b0;
    end

    assign rd.valid = out_valid_reg;
    assign rd.data  = out_data_reg;
endmodule // result_fifo
`default_nettype wire

// [hw/adc_power_mode_sequencer.sv]
// frame-select driven power-mode sequencer and serial output for a dual
// converter
`timescale 1ns/1ns
`default_nettype none
module adc_power_mode_sequencer #(
    parameter int FULL_WAKE_CYCLES = power_seq_pkg::FULL_WAKE_CYC
)
(
    input  wire logic                             mclk,
    input  wire logic                             rst,
    input  wire logic                             sample_frame_select_n,
    input  wire logic                             serial_clk,
    input  wire logic                             res_valid,
    output logic                                  res_ready,
    input  wire logic [power_seq_pkg::WORD_W-1:0] res_data,
    output logic                                  serial_out_a_o,
    output logic                                  serial_out_a_oe,
    output logic                                  serial_out_b_o,
    output logic                                  serial_out_b_oe,
    output logic                                  sample_start,
    output logic                                  analog_on,
    output logic                                  reference_on,
    output logic                                  powered_up
);
    logic                        cs_level;
    logic                        cs_rise;
    logic                        cs_fall;
    logic                        sclk_fall;
    logic                        frame_reg;
    logic [5:0]                  cnt_reg;
    logic [5:0]                  cnt_inc;
    logic                        count_evt;
    logic                        load_evt;
    logic [4:0]                  bit_idx;
    power_seq_pkg::pwr_mode_e    mode_reg;
    power_seq_pkg::pwr_mode_e    mode_next;
    logic [power_seq_pkg::WAKE_W-1:0] wake_cnt_reg;
    logic [31:0]                 frame_a_reg;
    logic [31:0]                 frame_b_reg;
    logic [power_seq_pkg::RES_W-1:0] res_a;
    logic [power_seq_pkg::RES_W-1:0] res_b;
    logic                        out_a_reg;
    logic                        out_b_reg;
    logic                        oe_reg;
    logic                        sample_start_reg;
    logic                        analog_on_reg;
    logic                        reference_on_reg;
    logic                        powered_up_reg;
    logic                        in_window;
    logic                        past_keep;

    stream_if #(.WIDTH(power_seq_pkg::WORD_W)) fill_s ();
    stream_if #(.WIDTH(power_seq_pkg::WORD_W)) drain_s ();

    pin_sync #(.INIT(power_seq_pkg::SELECT_IDLE)) select_sync
    (
        .clk   (mclk),
        .rst   (rst),
        .pin   (sample_frame_select_n),
        .level (cs_level),
        .rise  (cs_rise),
        .fall  (cs_fall)
    );

    pin_sync #(.INIT(power_seq_pkg::SCLK_IDLE)) sclk_sync
    (
        .clk   (mclk),
        .rst   (rst),
        .pin   (serial_clk),
        .level (),
        .rise  (),
        .fall  (sclk_fall)
    );

    result_fifo #(
        .WIDTH (power_seq_pkg::WORD_W),
        .DEPTH (power_seq_pkg::FIFO_DEPTH)
    ) buffer
    (
        .clk (mclk),
        .rst (rst),
        .wr  (fill_s.snk),
        .rd  (drain_s.src)
    );

    assign fill_s.valid = res_valid;
    assign fill_s.data  = res_data;
    assign res_ready    = fill_s.ready;

    // edges are counted only inside a frame; an edge landing with the
    // select fall is dropped and the counter holds at saturation
    assign count_evt = frame_reg && sclk_fall && !cs_fall && !cs_rise
                       && (cnt_reg != power_seq_pkg::CNT_SAT);
    assign cnt_inc   = cnt_reg + 6'h01;
    assign load_evt  = count_evt && (cnt_inc == power_seq_pkg::CNT_LOAD);
    assign bit_idx   = 5'(power_seq_pkg::FRAME_TOP - cnt_inc);
    assign drain_s.ready = load_evt;
    assign res_a     = drain_s.valid ?
                       drain_s.data[power_seq_pkg::WORD_W-1 -:
                                    power_seq_pkg::RES_W] : '0;
    assign res_b     = drain_s.valid ?
                       drain_s.data[power_seq_pkg::RES_W-1:0] : '0;

    assign in_window = (cnt_reg >= power_seq_pkg::CNT_GLITCH)
                       && (cnt_reg < power_seq_pkg::CNT_KEEP);
    assign past_keep = (cnt_reg >= power_seq_pkg::CNT_KEEP);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            frame_reg <= 1'b0;
        else if (cs_fall)
            frame_reg <= 1'b1;
        else if (cs_rise)
            frame_reg <= 1'b0;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cnt_reg <= '0;
        else if (cs_fall)
            cnt_reg <= '0;
        else if (count_evt)
            cnt_reg <= cnt_inc;
    end

    // mode decision taken from the edge count at the select rise
    always_comb
    begin
        mode_next = mode_reg;
        if (cs_rise && frame_reg)
        begin
            case (mode_reg)
                power_seq_pkg::MODE_NORMAL:
                begin
                    if (in_window)
                        mode_next = power_seq_pkg::MODE_PARTIAL;
                    else
                        mode_next = power_seq_pkg::MODE_NORMAL;
                end
                power_seq_pkg::MODE_PARTIAL:
                begin
                    if (past_keep)
                        mode_next = power_seq_pkg::MODE_NORMAL;
                    else if (in_window)
                        mode_next = power_seq_pkg::MODE_FULL;
                    else
                        mode_next = power_seq_pkg::MODE_PARTIAL;
                end
                power_seq_pkg::MODE_FULL:
                begin
                    if (past_keep)
                        mode_next = power_seq_pkg::MODE_NORMAL;
                    else
                        mode_next = power_seq_pkg::MODE_FULL;
                end
                default:
                    mode_next = power_seq_pkg::MODE_NORMAL;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            mode_reg <= power_seq_pkg::MODE_NORMAL;
        else
            mode_reg <= mode_next;
    end

    // wake timer starts at the dummy conversion's select fall
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            wake_cnt_reg <= '0;
        else if (cs_fall && mode_reg == power_seq_pkg::MODE_PARTIAL)
            wake_cnt_reg <= power_seq_pkg::WAKE_W'(
                power_seq_pkg::PARTIAL_WAKE_CYC);
        else if (cs_fall && mode_reg == power_seq_pkg::MODE_FULL)
            wake_cnt_reg <= power_seq_pkg::WAKE_W'(FULL_WAKE_CYCLES);
        else if (cs_rise && frame_reg && !past_keep
                 && mode_reg != power_seq_pkg::MODE_NORMAL)
            wake_cnt_reg <= '0;
        else if (wake_cnt_reg != '0)
            wake_cnt_reg <= wake_cnt_reg - 1'b1;
    end

    // frame words: two lead zeros, result, four zeros, other result, two
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            frame_a_reg <= '0;
            frame_b_reg <= '0;
        end
        else if (load_evt)
        begin
            frame_a_reg <= {power_seq_pkg::LEAD_ZEROS, res_a,
                            power_seq_pkg::GAP_ZEROS, res_b,
                            power_seq_pkg::LEAD_ZEROS};
            frame_b_reg <= {power_seq_pkg::LEAD_ZEROS, res_b,
                            power_seq_pkg::GAP_ZEROS, res_a,
                            power_seq_pkg::LEAD_ZEROS};
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            oe_reg    <= 1'b0;
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
        end
        else if (cs_fall)
        begin
            oe_reg    <= 1'b1;
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
        end
        else if (cs_rise)
        begin
            oe_reg    <= 1'b0;
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
        end
        else if (count_evt)
        begin
            if (cnt_inc >= power_seq_pkg::CNT_LAST)
            begin
                oe_reg    <= 1'b0;
                out_a_reg <= 1'b0;
                out_b_reg <= 1'b0;
            end
            else if (load_evt)
            begin
                out_a_reg <= 1'b0;
                out_b_reg <= 1'b0;
            end
            else
            begin
                out_a_reg <= frame_a_reg[bit_idx];
                out_b_reg <= frame_b_reg[bit_idx];
            end
        end
    end

    // power domains follow the mode; a frame powers them up meanwhile
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sample_start_reg <= 1'b0;
            analog_on_reg    <= 1'b1;
            reference_on_reg <= 1'b1;
            powered_up_reg   <= 1'b0;
        end
        else
        begin
            sample_start_reg <= cs_fall;
            analog_on_reg    <= (mode_reg == power_seq_pkg::MODE_NORMAL)
                                || frame_reg;
            reference_on_reg <= (mode_reg != power_seq_pkg::MODE_FULL)
                                || frame_reg;
            powered_up_reg   <= (mode_reg == power_seq_pkg::MODE_NORMAL)
                                && (wake_cnt_reg == '0);
        end
    end

    assign serial_out_a_o  = out_a_reg;
    assign serial_out_b_o  = out_b_reg;
    assign serial_out_a_oe = oe_reg;
    assign serial_out_b_oe = oe_reg;
    assign sample_start    = sample_start_reg;
    assign analog_on       = analog_on_reg;
    assign reference_on    = reference_on_reg;
    assign powered_up      = powered_up_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    drive_start_a: assert property (
        cs_fall |=> serial_out_a_oe && serial_out_b_oe && !serial_out_a_o)
        else $error("outputs not driven after select fall");
    release_rise_a: assert property (
        cs_rise |=> !serial_out_a_oe && !serial_out_b_oe)
        else $error("outputs still driven after select rise");
    count_clear_a: assert property (
        cs_fall |=> cnt_reg == 6'h00)
        else $error("edge count not cleared by select fall");
    count_sat_a: assert property (
        cnt_reg <= power_seq_pkg::CNT_SAT)
        else $error("edge count beyond saturation");
    glitch_keep_a: assert property (
        cs_rise && frame_reg && cnt_reg < power_seq_pkg::CNT_GLITCH
        |=> mode_reg == $past(mode_reg))
        else $error("early rise changed the mode");
    partial_entry_a: assert property (
        cs_rise && frame_reg && in_window
        && mode_reg == power_seq_pkg::MODE_NORMAL
        |=> mode_reg == power_seq_pkg::MODE_PARTIAL)
        else $error("window rise did not enter partial");
    full_entry_a: assert property (
        cs_rise && frame_reg && in_window
        && mode_reg == power_seq_pkg::MODE_PARTIAL
        |=> mode_reg == power_seq_pkg::MODE_FULL)
        else $error("window rise in partial did not enter full");
    stay_on_a: assert property (
        cs_rise && frame_reg && past_keep
        |=> mode_reg == power_seq_pkg::MODE_NORMAL)
        else $error("late rise did not leave device powered");
    tail_zero_a: assert property (
        serial_out_a_oe && cnt_reg >= power_seq_pkg::CNT_DATA
        && cnt_reg <= power_seq_pkg::CNT_TAIL |-> !serial_out_a_o)
        else $error("trailing bits not zero");
    hold_after_a: assert property (
        serial_out_a_oe && cnt_reg == power_seq_pkg::CNT_DATA
        && !cs_rise |=> serial_out_a_oe)
        else $error("output released after result without rise");
    last_edge_a: assert property (
        count_evt && cnt_reg == power_seq_pkg::FRAME_TOP
        |=> !serial_out_a_oe && !serial_out_b_oe)
        else $error("output driven after last edge");
    full_ref_a: assert property (
        (mode_reg == power_seq_pkg::MODE_FULL && !frame_reg) [*2]
        |-> !reference_on)
        else $error("reference powered in full power-down");
    partial_ref_a: assert property (
        (mode_reg == power_seq_pkg::MODE_PARTIAL && !frame_reg) [*2]
        |-> reference_on && !analog_on)
        else $error("partial power-down domains wrong");
    wake_load_a: assert property (
        cs_fall && mode_reg == power_seq_pkg::MODE_PARTIAL
        |=> wake_cnt_reg == power_seq_pkg::WAKE_W'(
            power_seq_pkg::PARTIAL_WAKE_CYC) && !powered_up)
        else $error("partial wake timer not started");

    partial_seen_c: cover property (
        cs_rise && in_window && mode_reg == power_seq_pkg::MODE_NORMAL);
    full_seen_c: cover property (
        cs_rise && in_window && mode_reg == power_seq_pkg::MODE_PARTIAL);
    dual_read_c: cover property (
        count_evt && cnt_reg == power_seq_pkg::FRAME_TOP);
    wake_seen_c: cover property (
        cs_rise && past_keep && mode_reg == power_seq_pkg::MODE_FULL);
endmodule // adc_power_mode_sequencer
`default_nettype wire

// [verif/host_model.sv]
// serial port master model driving frame select and the serial clock
`timescale 1ns/1ns
`default_nettype none
module host_model
(
    input  wire logic mclk,
    output logic      select_n,
    output logic      sclk,
    input  wire logic out_a,
    input  wire logic out_a_oe,
    input  wire logic out_b,
    input  wire logic out_b_oe
);
    logic [40:0] cap_a;
    logic [40:0] cap_b;
    logic [40:0] cap_oe;

    initial
    begin
        select_n = 1'b1;
        sclk     = 1'b0;
    end

    // one position per line; enables must agree
    task automatic grab(input int p);
        cap_a[p]  = out_a;
        cap_b[p]  = out_b;
        cap_oe[p] = (out_a_oe === out_b_oe) ? out_a_oe : 1'bx;
    endtask

    // sclk idles low; a frame may end early
    task automatic run(input int edges, input int hold);
        cap_a  = '0;
        cap_b  = '0;
        cap_oe = '0;
        // a parked high sclk falls with select here and must not count
        @(posedge mclk);
        select_n <= 1'b0;
        sclk     <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int k = 1; k <= edges; k++)
        begin
            sclk <= 1'b1;
            repeat (3) @(posedge mclk);
            @(negedge mclk) grab(k - 1);
            @(posedge mclk) sclk <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        repeat (hold) @(posedge mclk);
        @(negedge mclk) grab(edges);
        @(posedge mclk) select_n <= 1'b1;
        // quiet gap before any next frame
        repeat (24) @(posedge mclk);
        @(negedge mclk);
    endtask

    // park sclk high so its next fall meets the select fall
    task automatic park_high();
        @(posedge mclk) sclk <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
endmodule // host_model
`default_nettype wire

// [verif/adc_power_mode_sequencer_bench.sv]
// self-checking bench for the power-mode sequencer
`timescale 1ns/1ns
`default_nettype none
module adc_power_mode_sequencer_bench;
    localparam int WAKE  = 200;
    localparam int LIMIT = 20000;
    // 67 us of partial stay at 20 ns per cycle
    localparam int PART_STAY = 3350;
    logic        mclk      = 1'b0;
    logic        rst       = 1'b1;
    logic        res_valid = 1'b0;
    logic [23:0] res_data  = 24'h00_0000;
    wire logic   sel_n;
    wire logic   sclk;
    logic        res_ready;
    logic        oa;
    logic        oa_oe;
    logic        ob;
    logic        ob_oe;
    logic        sample_start;
    logic        analog_on;
    logic        reference_on;
    logic        powered_up;
    int          n_errors  = 0;
    int          compares  = 0;
    int          cycles    = 0;
    int          n_starts  = 0;

    always #10 mclk = ~mclk;

    adc_power_mode_sequencer #(.FULL_WAKE_CYCLES(WAKE)) dut_u (
        .mclk(mclk), .rst(rst), .sample_frame_select_n(sel_n),
        .serial_clk(sclk), .res_valid(res_valid), .res_ready(res_ready),
        .res_data(res_data), .serial_out_a_o(oa), .serial_out_a_oe(oa_oe),
        .serial_out_b_o(ob), .serial_out_b_oe(ob_oe),
        .sample_start(sample_start), .analog_on(analog_on),
        .reference_on(reference_on), .powered_up(powered_up));

    host_model host_u (
        .mclk(mclk), .select_n(sel_n), .sclk(sclk), .out_a(oa),
        .out_a_oe(oa_oe), .out_b(ob), .out_b_oe(ob_oe));

    task automatic results();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (sample_start === 1'b1)
            n_starts <= n_starts + 1;
        if (cycles == LIMIT)
        begin
            n_errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    // positions 0..31: zeros, own result, zeros, other result, zeros
    function automatic logic [31:0] exp_line(input logic [23:0] w,
                                             input logic sw);
        logic [11:0] f;
        logic [11:0] s;
        logic [31:0] v;
        f = sw ? w[11:0] : w[23:12];
        s = sw ? w[23:12] : w[11:0];
        v = '0;
        for (int i = 0; i < 12; i++)
        begin
            v[13 - i] = f[i];
            v[29 - i] = s[i];
        end
        return v;
    endfunction

    task automatic chk_frame(input logic [23:0] w, input logic [31:0] m);
        chk(host_u.cap_a[31:0] & m, exp_line(w, 1'b0) & m);
        chk(host_u.cap_b[31:0] & m, exp_line(w, 1'b1) & m);
        chk(host_u.cap_oe[31:0] & m, m);
    endtask

    task automatic push(input logic [23:0] w, output logic ok);
        ok = 1'b0;
        @(posedge mclk);
        res_valid <= 1'b1;
        res_data  <= w;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            @(negedge mclk);
            if (res_ready === 1'b1)
                ok = 1'b1;
            @(posedge mclk);
        end
        res_valid <= 1'b0;
    endtask

    task automatic t_normal();
        logic ok;
        int   s0;
        s0 = n_starts;
        push(24'ha5_c3e1, ok);
        host_u.run(32, 20);
        chk_frame(24'ha5_c3e1, 32'hffff_ffff);
        chk(host_u.cap_oe[40:32], 9'h000);
        chk(n_starts - s0, 1);
        host_u.run(40, 4);
        chk(host_u.cap_oe[40:32], 9'h000);
        chk({analog_on, reference_on, powered_up}, 3'h7);
        done("normal");
    endtask

    task automatic t_abort();
        logic ok;
        push(24'h3c_96a5, ok);
        host_u.run(12, 4);
        chk_frame(24'h3c_96a5, 32'h0000_1fff);
        chk({oa_oe, ob_oe, analog_on, powered_up}, 4'h3);
        host_u.run(1, 4);
        chk({analog_on, reference_on, powered_up}, 3'h7);
        push(24'h5a_0f3c, ok);
        host_u.park_high();
        host_u.run(14, 4);
        chk_frame(24'h5a_0f3c, 32'h0000_7fff);
        done("abort_glitch");
    endtask

    task automatic t_power();
        host_u.run(12, 4);
        chk({analog_on, reference_on, powered_up}, 3'h7);
        host_u.run(5, 4);
        chk({analog_on, reference_on, powered_up, oa_oe}, 4'h4);
        host_u.run(1, 4);
        chk({analog_on, reference_on, powered_up}, 3'h2);
        host_u.run(5, 4);
        chk({analog_on, reference_on, powered_up}, 3'h0);
        host_u.run(10, 4);
        chk({analog_on, powered_up}, 2'h2);
        for (int i = 0; i < WAKE && powered_up !== 1'b1; i++)
            @(negedge mclk);
        chk(powered_up, 1'b1);
        host_u.run(5, 4);
        chk({analog_on, reference_on, powered_up}, 3'h2);
        repeat (PART_STAY) @(posedge mclk);
        host_u.run(12, 4);
        chk({analog_on, reference_on, powered_up}, 3'h7);
        done("power");
    endtask

    task automatic t_fifo();
        logic ok;
        int   n;
        n  = 0;
        ok = 1'b1;
        while (ok && n < 20)
        begin
            push({12'h800 | 12'(n), 12'h001 << (n % 12)}, ok);
            if (ok)
                n++;
        end
        chk(n >= 16 && n <= 17, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            host_u.run(14, 4);
            chk_frame({12'h800 | 12'(i), 12'h001 << (i % 12)},
                      32'h0000_7fff);
        end
        host_u.run(14, 4);
        chk_frame(24'h00_0000, 32'h0000_7fff);
        done("fifo");
    endtask

    initial
    begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_normal();
        t_abort();
        t_power();
        t_fifo();
        results();
    end
endmodule // adc_power_mode_sequencer_bench
`default_nettype wire
